// file: rtl/pcd_defines.svh
// Register map, field positions, reset values and limits of the DMA engine
`ifndef PCD_DEFINES_SVH
`define PCD_DEFINES_SVH
// Register byte offsets on APB
`define PCD_A_CFG 8'h00
`define PCD_A_STATUS 8'h04
`define PCD_A_MASK 8'h08
`define PCD_A_CPTR_LO 8'h0C
`define PCD_A_CPTR_HI 8'h10
`define PCD_A_LADDR 8'h14
`define PCD_A_PADDR 8'h18
`define PCD_A_COUNT 8'h1C
// Configuration register fields
`define PCD_CFG_CHRST 0
`define PCD_CFG_START 1
`define PCD_CFG_DIR 2
`define PCD_CFG_SIZE_LO 3
`define PCD_CFG_SIZE_HI 4
`define PCD_CFG_CDIE 8
`define PCD_CFG_XDIE 9
`define PCD_CFG_ERIE 10
`define PCD_CFG_CHACT 12
`define PCD_CFG_RST 32'h0000_0001
`define PCD_CFG_WM_IDLE 32'h0000_071D
`define PCD_CFG_WM_BUSY 32'h0000_0701
// Status and mask register fields
`define PCD_ST_W 10
`define PCD_ST_STALL 0
`define PCD_ST_SETUP 1
`define PCD_ST_PCIF 2
`define PCD_ST_FETCH 3
`define PCD_ST_DATA 4
`define PCD_ST_XDONE 8
`define PCD_ST_CDONE 9
`define PCD_ERR_MASK 10'h01F
`define PCD_MASK_RST 10'h31F
// Descriptor layout: chain 0x00, local 0x08, PCI 0x10, count 0x18
`define PCD_D_SHIFT 3
`define PCD_D_CHAIN 2'h0
`define PCD_D_LADDR 2'h1
`define PCD_D_PADDR 2'h2
`define PCD_D_COUNT 2'h3
// Transfer units and limits
`define PCD_DW_BYTES 32'h0000_0004
`define PCD_QW_BYTES 32'h0000_0008
`define PCD_ALIGN_HI 2
`define PCD_STALL_LIMIT 16'h0100
`define PCD_IRQ_NUM 5'h0F
`endif

// file: rtl/pcd_dma.sv
// PCI DMA engine: APB registers, descriptor chaining, mover, interrupt
`include "pcd_defines.svh"
module pcd_dma (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Local memory master
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [63:0] mem_wdata,
  output logic [1:0] mem_size,
  input wire logic mem_ack,
  input wire logic mem_err,
  input wire logic [63:0] mem_rdata,
  // PCI side master, four-phase handshake
  input wire logic pci_clk,
  output logic pci_req,
  output logic pci_we,
  output logic [31:0] pci_addr,
  output logic [63:0] pci_wdata,
  output logic [1:0] pci_size,
  input wire logic pci_ack,
  input wire logic pci_err,
  input wire logic [63:0] pci_rdata,
  // Interrupt
  output logic irq,
  output logic [4:0] irq_num
);
  pcd_pkg::pcd_state_t state, next_state;
  pcd_pkg::pcd_size_t size_sel;
  logic pci_clk_s, pci_ack_s, pci_err_s, pci_clk_q;
  logic [63:0] pci_rdata_s;
  logic [1:0] fetch_idx, next_fetch_idx;
  logic chain_active, next_chain_active, chain_more, next_chain_more;
  logic [31:0] desc_base, next_desc_base;
  logic [63:0] data_buf, next_data_buf, rd_word;
  logic [15:0] stall_cnt, next_stall_cnt;
  logic [31:0] cfg, next_cfg, cfg_wm;
  logic [`PCD_ST_W-1:0] mask, next_mask, status, st_set, st_clr, en_vec;
  logic [63:0] chain_pointer_reg, next_cptr;
  logic [31:0] local_addr_reg, next_laddr, pci_addr_reg, next_paddr;
  logic [31:0] byte_count_reg, next_count, unit, rd_mux;
  logic next_mem_req, next_mem_we, next_pci_req, next_pci_we;
  logic [31:0] next_mem_addr, next_pci_addr;
  logic [63:0] next_mem_wdata, next_pci_wdata;
  logic [1:0] next_mem_size, next_pci_size;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_irq, rd_ok;
  logic apb_wr, busy, pci_edge, setup_bad, abort, step_done, to_pci;

  // Link inputs pass two flip-flops before use
  pcd_sync #(.W(1)) u_sync_clk (.clk_sys(clk_sys), .rst(rst),
    .din(pci_clk), .dout(pci_clk_s));
  pcd_sync #(.W(1)) u_sync_ack (.clk_sys(clk_sys), .rst(rst),
    .din(pci_ack), .dout(pci_ack_s));
  pcd_sync #(.W(1)) u_sync_err (.clk_sys(clk_sys), .rst(rst),
    .din(pci_err), .dout(pci_err_s));
  pcd_sync #(.W(64)) u_sync_dat (.clk_sys(clk_sys), .rst(rst),
    .din(pci_rdata), .dout(pci_rdata_s));

  // Sticky status flags
  pcd_sticky #(.W(`PCD_ST_W)) u_status (.clk_sys(clk_sys), .rst(rst),
    .set(st_set), .clr(st_clr), .q(status));

  // Decodes and derived values
  assign apb_wr = psel & penable & pready & pwrite;
  assign busy = (state != pcd_pkg::st_idle);
  assign pci_edge = pci_clk_s & ~pci_clk_q;
  assign size_sel =
    pcd_pkg::pcd_size_t'(cfg[`PCD_CFG_SIZE_HI:`PCD_CFG_SIZE_LO]);
  assign unit = (size_sel == pcd_pkg::sz_dword) ? `PCD_DW_BYTES
                                                : `PCD_QW_BYTES;
  assign setup_bad = (size_sel == pcd_pkg::sz_bad) |
    ((size_sel != pcd_pkg::sz_dword) &
     (|{local_addr_reg[`PCD_ALIGN_HI:0], pci_addr_reg[`PCD_ALIGN_HI:0],
        byte_count_reg[`PCD_ALIGN_HI:0]}));
  assign cfg_wm = busy ? `PCD_CFG_WM_BUSY : `PCD_CFG_WM_IDLE;

  // Interrupt enables laid out like the status register
  always_comb
  begin
    en_vec = `PCD_ERR_MASK & {`PCD_ST_W{cfg[`PCD_CFG_ERIE]}};
    en_vec[`PCD_ST_XDONE] = cfg[`PCD_CFG_XDIE];
    en_vec[`PCD_ST_CDONE] = cfg[`PCD_CFG_CDIE];
    next_irq = |(status & mask & en_vec);
  end

  // Register read mux
  always_comb
  begin
    rd_ok = 1'b1;
    rd_mux = '0;
    case (paddr)
      `PCD_A_CFG:
      begin
        rd_mux = cfg;
        rd_mux[`PCD_CFG_CHACT] = chain_active;
      end
      `PCD_A_STATUS: rd_mux[`PCD_ST_W-1:0] = status;
      `PCD_A_MASK: rd_mux[`PCD_ST_W-1:0] = mask;
      `PCD_A_CPTR_LO: rd_mux = chain_pointer_reg[31:0];
      `PCD_A_CPTR_HI: rd_mux = chain_pointer_reg[63:32];
      `PCD_A_LADDR: rd_mux = local_addr_reg;
      `PCD_A_PADDR: rd_mux = pci_addr_reg;
      `PCD_A_COUNT: rd_mux = byte_count_reg;
      default: rd_ok = 1'b0;
    endcase
  end

  // APB answer: ready in the first access cycle
  always_comb
  begin
    next_pready = psel & ~penable;
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (psel & ~penable)
    begin
      next_prdata = rd_mux;
      next_pslverr = ~rd_ok;
    end
  end

  // Register writes and the transfer sequencer
  always_comb
  begin
    next_state = state;
    next_fetch_idx = fetch_idx;
    next_chain_active = chain_active;
    next_chain_more = chain_more;
    next_desc_base = desc_base;
    next_data_buf = data_buf;
    next_stall_cnt = stall_cnt;
    next_cfg = cfg;
    next_mask = mask;
    next_cptr = chain_pointer_reg;
    next_laddr = local_addr_reg;
    next_paddr = pci_addr_reg;
    next_count = byte_count_reg;
    next_mem_req = mem_req;
    next_mem_we = mem_we;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    next_mem_size = mem_size;
    next_pci_req = pci_req;
    next_pci_we = pci_we;
    next_pci_addr = pci_addr;
    next_pci_wdata = pci_wdata;
    next_pci_size = pci_size;
    st_set = '0;
    st_clr = '0;
    abort = 1'b0;
    step_done = 1'b0;
    rd_word = '0;
    to_pci = (state == pcd_pkg::st_read) ? cfg[`PCD_CFG_DIR]
                                         : ~cfg[`PCD_CFG_DIR];
    if (apb_wr)
    begin
      case (paddr)
        `PCD_A_CFG:
        begin
          next_cfg = (cfg & ~cfg_wm) | (pwdata & cfg_wm);
          if (!busy && pwdata[`PCD_CFG_START] && !pwdata[`PCD_CFG_CHRST])
          begin
            next_cfg[`PCD_CFG_START] = 1'b1;
            next_state = pcd_pkg::st_check;
          end
        end
        `PCD_A_STATUS: st_clr = pwdata[`PCD_ST_W-1:0];
        `PCD_A_MASK: next_mask = pwdata[`PCD_ST_W-1:0];
        `PCD_A_CPTR_LO:
          if (!busy)
          begin
            next_cptr[31:0] = pwdata;
            if ({chain_pointer_reg[63:32], pwdata} != '0 &&
                !cfg[`PCD_CFG_CHRST])
            begin
              next_state = pcd_pkg::st_fetch;
              next_chain_active = 1'b1;
              next_cfg[`PCD_CFG_START] = 1'b1;
              next_desc_base = pwdata;
              next_fetch_idx = `PCD_D_CHAIN;
            end
          end
        `PCD_A_CPTR_HI: if (!busy) next_cptr[63:32] = pwdata;
        `PCD_A_LADDR: if (!busy) next_laddr = pwdata;
        `PCD_A_PADDR: if (!busy) next_paddr = pwdata;
        `PCD_A_COUNT: if (!busy) next_count = pwdata;
        default: ;
      endcase
    end
    unique case (state)
      pcd_pkg::st_idle: next_stall_cnt = '0;
      pcd_pkg::st_fetch:
        if (!mem_req)
        begin
          next_mem_req = 1'b1;
          next_mem_we = 1'b0;
          next_mem_size = pcd_pkg::sz_qword;
          next_mem_addr = desc_base +
            (32'(fetch_idx) << `PCD_D_SHIFT);
        end
        else if (mem_ack)
        begin
          next_mem_req = 1'b0;
          if (mem_err)
          begin
            st_set[`PCD_ST_FETCH] = 1'b1;
            abort = 1'b1;
          end
          else
          begin
            unique case (fetch_idx)
              `PCD_D_CHAIN:
              begin
                next_chain_more = |mem_rdata;
                if (|mem_rdata)
                  next_cptr = mem_rdata;
              end
              `PCD_D_LADDR: next_laddr = mem_rdata[31:0];
              `PCD_D_PADDR: next_paddr = mem_rdata[31:0];
              `PCD_D_COUNT: next_count = mem_rdata[31:0];
            endcase
            if (fetch_idx == `PCD_D_COUNT)
              next_state = pcd_pkg::st_check;
            next_fetch_idx = fetch_idx + 2'h1;
          end
        end
      pcd_pkg::st_check:
        if (setup_bad)
        begin
          st_set[`PCD_ST_SETUP] = 1'b1;
          abort = 1'b1;
        end
        else if (byte_count_reg == '0)
          next_state = pcd_pkg::st_next;
        else
          next_state = pcd_pkg::st_read;
      pcd_pkg::st_read, pcd_pkg::st_write:
      begin
        if (!to_pci)
        begin
          if (!mem_req)
          begin
            next_mem_req = 1'b1;
            next_mem_we = (state == pcd_pkg::st_write);
            next_mem_addr = local_addr_reg;
            next_mem_wdata = data_buf;
            next_mem_size = size_sel;
          end
          else if (mem_ack)
          begin
            next_mem_req = 1'b0;
            step_done = ~mem_err;
            rd_word = mem_rdata;
            st_set[`PCD_ST_DATA] = mem_err;
            abort = mem_err;
          end
        end
        else if (!pci_req && !pci_ack_s)
        begin
          next_pci_req = 1'b1;
          next_pci_we = (state == pcd_pkg::st_write);
          next_pci_addr = pci_addr_reg;
          next_pci_wdata = data_buf;
          next_pci_size = size_sel;
          next_stall_cnt = '0;
        end
        else if (pci_req && pci_ack_s)
        begin
          next_pci_req = 1'b0;
          step_done = ~pci_err_s;
          rd_word = pci_rdata_s;
          st_set[`PCD_ST_PCIF] = pci_err_s;
          abort = pci_err_s;
        end
        else if (pci_req && pci_edge)
        begin
          next_stall_cnt = stall_cnt + 16'h0001;
          if (stall_cnt == `PCD_STALL_LIMIT)
          begin
            st_set[`PCD_ST_STALL] = 1'b1;
            abort = 1'b1;
          end
        end
        if (step_done && state == pcd_pkg::st_read)
        begin
          next_data_buf = rd_word;
          next_state = pcd_pkg::st_write;
        end
        else if (step_done)
        begin
          next_laddr = local_addr_reg + unit;
          next_paddr = pci_addr_reg + unit;
          next_count = byte_count_reg - unit;
          next_state = pcd_pkg::st_read;
          if (byte_count_reg <= unit)
          begin
            next_count = '0;
            next_state = pcd_pkg::st_next;
          end
        end
      end
      pcd_pkg::st_next:
      begin
        st_set[`PCD_ST_XDONE] = 1'b1;
        if (chain_active && chain_more)
        begin
          next_state = pcd_pkg::st_fetch;
          next_desc_base = chain_pointer_reg[31:0];
          next_fetch_idx = `PCD_D_CHAIN;
        end
        else
        begin
          st_set[`PCD_ST_CDONE] = chain_active;
          next_chain_active = 1'b0;
          next_cfg[`PCD_CFG_START] = 1'b0;
          next_state = pcd_pkg::st_idle;
        end
      end
      default: next_state = pcd_pkg::st_idle;
    endcase
    // Abort or channel reset drops every request
    if (abort || cfg[`PCD_CFG_CHRST])
    begin
      next_state = pcd_pkg::st_idle;
      next_chain_active = 1'b0;
      next_cfg[`PCD_CFG_START] = 1'b0;
      next_mem_req = 1'b0;
      next_pci_req = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state <= pcd_pkg::st_idle;
      fetch_idx <= '0;
      chain_active <= 1'b0;
      chain_more <= 1'b0;
      desc_base <= '0;
      data_buf <= '0;
      stall_cnt <= '0;
      pci_clk_q <= 1'b0;
      cfg <= `PCD_CFG_RST;
      mask <= `PCD_MASK_RST;
      chain_pointer_reg <= '0;
      local_addr_reg <= '0;
      pci_addr_reg <= '0;
      byte_count_reg <= '0;
      {mem_req, mem_we, mem_addr, mem_wdata, mem_size} <= '0;
      {pci_req, pci_we, pci_addr, pci_wdata, pci_size} <= '0;
      {prdata, pready, pslverr, irq} <= '0;
      irq_num <= `PCD_IRQ_NUM;
    end
    else
    begin
      state <= next_state;
      fetch_idx <= next_fetch_idx;
      chain_active <= next_chain_active;
      chain_more <= next_chain_more;
      desc_base <= next_desc_base;
      data_buf <= next_data_buf;
      stall_cnt <= next_stall_cnt;
      pci_clk_q <= pci_clk_s;
      cfg <= next_cfg;
      mask <= next_mask;
      chain_pointer_reg <= next_cptr;
      local_addr_reg <= next_laddr;
      pci_addr_reg <= next_paddr;
      byte_count_reg <= next_count;
      mem_req <= next_mem_req;
      mem_we <= next_mem_we;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
      mem_size <= next_mem_size;
      pci_req <= next_pci_req;
      pci_we <= next_pci_we;
      pci_addr <= next_pci_addr;
      pci_wdata <= next_pci_wdata;
      pci_size <= next_pci_size;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
      irq_num <= `PCD_IRQ_NUM;
    end
  end

  // Checks
  sequence s_cptr_go;
    apb_wr && paddr == `PCD_A_CPTR_LO && pwdata != '0 && !busy &&
    !cfg[`PCD_CFG_CHRST];
  endsequence
  sequence s_desc_end;
    state == pcd_pkg::st_next && !cfg[`PCD_CFG_CHRST];
  endsequence
  a_chain_start: assert property (@(posedge clk_sys) disable iff (rst)
    s_cptr_go |=> state == pcd_pkg::st_fetch ##1 mem_req)
    else $error("chain did not start");
  a_xfer_done: assert property (@(posedge clk_sys) disable iff (rst)
    s_desc_end |=> status[`PCD_ST_XDONE])
    else $error("transfer done flag missing");
  a_chain_done: assert property (@(posedge clk_sys) disable iff (rst)
    s_desc_end and chain_active && !chain_more
    |=> status[`PCD_ST_CDONE] && !chain_active)
    else $error("chain done flag missing");
  a_next_fetch: assert property (@(posedge clk_sys) disable iff (rst)
    s_desc_end and chain_active && chain_more
    |=> state == pcd_pkg::st_fetch &&
        desc_base == chain_pointer_reg[31:0])
    else $error("next descriptor not fetched");
  a_chain_hold: assert property (@(posedge clk_sys) disable iff (rst)
    state == pcd_pkg::st_fetch && mem_req && mem_ack && !mem_err &&
    fetch_idx == `PCD_D_CHAIN && mem_rdata == '0
    |=> !chain_more && $stable(chain_pointer_reg))
    else $error("pointer changed on zero chain field");
  a_setup_abort: assert property (@(posedge clk_sys) disable iff (rst)
    state == pcd_pkg::st_check && setup_bad
    |=> state == pcd_pkg::st_idle && status[`PCD_ST_SETUP] && !mem_req)
    else $error("setup error not aborted");
  a_beat_size: assert property (@(posedge clk_sys) disable iff (rst)
    mem_req && state inside {pcd_pkg::st_read, pcd_pkg::st_write}
    |-> mem_size == size_sel)
    else $error("beat size differs from field");
  a_err_gate: assert property (@(posedge clk_sys) disable iff (rst)
    !cfg[`PCD_CFG_ERIE] && (status & mask & ~`PCD_ERR_MASK) == '0
    |=> !irq)
    else $error("error raised irq while disabled");
  a_irq_drop: assert property (@(posedge clk_sys) disable iff (rst)
    (status & mask & en_vec) == '0 |=> !irq)
    else $error("irq stayed high");
  a_irq_cause: assert property (@(posedge clk_sys) disable iff (rst)
    irq |-> $past(next_irq) && irq_num == `PCD_IRQ_NUM)
    else $error("irq without cause");
endmodule : pcd_dma

// file: rtl/pcd_pkg.sv
// Types shared by the DMA engine files
package pcd_pkg;
  typedef enum logic [2:0] {
    st_idle, st_fetch, st_check, st_read, st_write, st_next
  } pcd_state_t;
  typedef enum logic [1:0] {
    sz_dword, sz_qword, sz_burst, sz_bad
  } pcd_size_t;
endpackage : pcd_pkg

// file: rtl/pcd_sticky.sv
// Sticky status bits, set by hardware, cleared by writing one
module pcd_sticky #(
  parameter int W = 10
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Set and clear strobes
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] q
);
  logic [W-1:0] next_q;

  // Set wins over a clear in the same cycle
  always_comb
  begin
    next_q = (q & ~clr) | set;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      q <= '0;
    else
      q <= next_q;
  end

  a_set_wins: assert property (@(posedge clk_sys) disable iff (rst)
    (|set) |=> ((q & $past(set)) == $past(set)))
    else $error("status event lost");
endmodule : pcd_sticky

// file: rtl/pcd_sync.sv
// Two flip-flop synchroniser for inputs from outside the system clock
module pcd_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta;

  // Only the second stage reads the first
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      meta <= '0;
      dout <= '0;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : pcd_sync

// file: tb/pcd_dma_bench.sv
// Self-checking bench of the DMA engine driven over APB
`include "pcd_defines.svh"
module pcd_dma_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic mem_fail = 1'b0;
  logic pci_stall = 1'b0;
  logic pci_fail = 1'b0;
  logic pready, pslverr, mem_req, mem_we, mem_ack, mem_err, irq, rerr;
  logic pci_clk, pci_req, pci_we, pci_ack, pci_err;
  logic [31:0] prdata, mem_addr, pci_addr, pci_last_addr, rd;
  logic [63:0] mem_wdata, mem_rdata, pci_wdata, pci_rdata, pci_last_data;
  logic [1:0] mem_size, pci_size, pci_last_size;
  logic [4:0] irq_num;
  logic [31:0] exp_err [4] = '{32'h10, 32'h01, 32'h04, 32'h02};
  int n_pci_wr, base;
  int error_cnt = 0;
  int n_compared = 0;

  always #2.5 clk_sys = ~clk_sys;

  pcd_dma i_pcd_dma (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_size, .mem_ack, .mem_err, .mem_rdata, .pci_clk,
    .pci_req, .pci_we, .pci_addr, .pci_wdata, .pci_size, .pci_ack,
    .pci_err, .pci_rdata, .irq, .irq_num);

  pcd_partner i_pcd_partner (.clk_sys, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_ack, .mem_err, .mem_rdata, .pci_req, .pci_we,
    .pci_addr, .pci_wdata, .pci_size, .pci_clk, .pci_ack, .pci_err,
    .pci_rdata, .mem_fail, .pci_stall, .pci_fail, .n_pci_wr,
    .pci_last_addr, .pci_last_data, .pci_last_size);

  // Compare a seen value with the expected one
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer: setup, then access until ready is sampled
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Poll status until one of the given bits shows
  task automatic wait_st(input logic [31:0] bits);
    int k;
    for (k = 0; k < 2000; k++)
    begin
      apb(1'b0, `PCD_A_STATUS, 32'h0);
      if ((rd & bits) != 32'h0) break;
    end
  endtask : wait_st

  // Let the registered interrupt settle, then compare it
  task automatic irq_is(input logic v);
    repeat (3) @(posedge clk_sys);
    chk(irq, v);
  endtask : irq_is

  // Clear all status flags; the interrupt must fall
  task automatic clr;
    apb(1'b1, `PCD_A_STATUS, 32'h0000_03FF);
    irq_is(1'b0);
  endtask : clr

  // Program addresses and count, then configure and start
  task automatic go(input logic [31:0] c, la, pa, n);
    apb(1'b1, `PCD_A_LADDR, la);
    apb(1'b1, `PCD_A_PADDR, pa);
    apb(1'b1, `PCD_A_COUNT, n);
    apb(1'b1, `PCD_A_CFG, c);
    apb(1'b1, `PCD_A_CFG, c | 32'h2);
  endtask : go

  // Print the counts and the verdict, then stop
  task automatic end_of_test;
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, `PCD_A_CFG, 32'h0);
    chk(rd, `PCD_CFG_RST);
    apb(1'b0, `PCD_A_MASK, 32'h0);
    chk(rd, `PCD_MASK_RST);
    apb(1'b0, 8'h20, 32'h0);
    chk({rerr, rd}, {1'b1, 32'h0});
    chk(irq_num, `PCD_IRQ_NUM);
    // Same 16 bytes moved in dwords, quadwords and bursts
    i_pcd_partner.mem[4] = 64'h0123_4567_89AB_CDEF;
    for (int s = 0; s < 3; s++)
    begin
      base = n_pci_wr;
      go(32'h0200 | (s << 3), 32'h18, 32'h1000_0080, 32'h10);
      wait_st(32'h100);
      chk(rd, 32'h100);
      chk(pci_last_size, s);
      chk(n_pci_wr - base, s ? 2 : 4);
      chk(pci_last_addr, s ? 32'h1000_0088 : 32'h1000_008C);
      if (s > 0) chk(pci_last_data, i_pcd_partner.mem[4]);
      irq_is(1'b1);
      clr;
    end
    // PCI to local: one quadword lands in local memory
    go(32'h020C, 32'h28, 32'h1000_0400, 32'h8);
    wait_st(32'h100);
    chk(rd, 32'h100);
    chk(i_pcd_partner.mem[5], 64'hA5A5_0F0F_5A5A_F0F0);
    clr;
    // Data error, stall, PCI fatal and misaligned setup each abort
    for (int e = 0; e < 4; e++)
    begin
      mem_fail <= (e == 0);
      pci_stall <= (e == 1);
      pci_fail <= (e == 2);
      base = n_pci_wr;
      go((e == 3) ? 32'h0408 : 32'h0400, (e == 3) ? 32'h14 : 32'h10,
        32'h1000_0000, 32'h10);
      wait_st(32'h1F);
      chk(rd, exp_err[e]);
      if (e < 2) chk(n_pci_wr - base, 0);
      irq_is(1'b1);
      apb(1'b1, `PCD_A_CFG, 32'h0);
      irq_is(1'b0);
      clr;
    end
    mem_fail <= 1'b0;
    pci_stall <= 1'b0;
    pci_fail <= 1'b0;
    // Two-descriptor chain started by the pointer write
    i_pcd_partner.mem[8:11] = '{64'h60, 64'h18, 64'h1000_0100, 64'h8};
    i_pcd_partner.mem[12:15] = '{64'h0, 64'h18, 64'h1000_0200, 64'h8};
    i_pcd_partner.mem[16:19] = '{64'h0, 64'h18, 64'h1000_0300, 64'h8};
    apb(1'b1, `PCD_A_CFG, 32'h0108);
    apb(1'b1, `PCD_A_CPTR_HI, 32'h0);
    apb(1'b1, `PCD_A_CPTR_LO, 32'h40);
    wait_st(32'h200);
    chk(rd, 32'h300);
    irq_is(1'b1);
    chk(pci_last_addr, 32'h1000_0200);
    apb(1'b0, `PCD_A_CPTR_LO, 32'h0);
    chk(rd, 32'h60);
    apb(1'b1, `PCD_A_MASK, 32'h0);
    irq_is(1'b0);
    clr;
    apb(1'b1, `PCD_A_MASK, 32'h0000_031F);
    // Append a third descriptor and restart from its address 0x80
    i_pcd_partner.mem[12] = 64'h80;
    apb(1'b0, `PCD_A_CFG, 32'h0);
    chk(rd[12], 1'b0);
    apb(1'b1, `PCD_A_CPTR_LO, i_pcd_partner.mem[12][31:0]);
    wait_st(32'h200);
    chk(rd, 32'h300);
    chk(pci_last_addr, 32'h1000_0300);
    end_of_test;
  end

  // Watchdog against a hang
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    error_cnt++;
    end_of_test;
  end
endmodule : pcd_dma_bench

// file: tb/pcd_partner.sv
// Far-side model: local memory slave and PCI target with async handshake
module pcd_partner (
  // System clock
  input wire logic clk_sys,
  // Local memory slave
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [63:0] mem_wdata,
  output logic mem_ack,
  output logic mem_err,
  output logic [63:0] mem_rdata,
  // PCI target
  input wire logic pci_req,
  input wire logic pci_we,
  input wire logic [31:0] pci_addr,
  input wire logic [63:0] pci_wdata,
  input wire logic [1:0] pci_size,
  output logic pci_clk,
  output logic pci_ack,
  output logic pci_err,
  output logic [63:0] pci_rdata,
  // Fault controls and observation
  input wire logic mem_fail,
  input wire logic pci_stall,
  input wire logic pci_fail,
  output int n_pci_wr,
  output logic [31:0] pci_last_addr,
  output logic [63:0] pci_last_data,
  output logic [1:0] pci_last_size
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quadword array, descriptors as four words
  logic [63:0] mem [0:31];
  logic [1:0] mwait = 2'h0;
  logic pwait = 1'b0;
  initial
  begin
    {mem_ack, mem_err, pci_clk, pci_ack, pci_err} = 5'h00;
    {mem_rdata, pci_rdata, pci_last_data} = '0;
    {n_pci_wr, pci_last_addr, pci_last_size} = '0;
  end
  // Memory answers after two wait cycles with a one-cycle acknowledge
  always @(posedge clk_sys)
  begin
    mem_ack <= 1'b0;
    mem_err <= 1'b0;
    mem_rdata <= ~mem_rdata; // Read data is not held outside the ack
    if (mem_req && !mem_ack && mwait == 2'h2)
    begin
      mem_ack <= 1'b1;
      mem_err <= mem_fail;
      mem_rdata <= mem[mem_addr[7:3]];
      if (mem_we) mem[mem_addr[7:3]] <= mem_wdata;
      mwait <= 2'h0;
    end
    else if (mem_req && !mem_ack) mwait <= mwait + 2'h1;
  end
  // Link clock runs only while a handshake is open
  always
  begin
    #24;
    if (pci_req || pci_ack) pci_clk = ~pci_clk;
  end
  // Four-phase target: ack on second link edge, drop after request falls
  always @(posedge pci_clk)
  begin
    if (pci_ack && !pci_req)
    begin
      pci_ack <= 1'b0;
      pci_err <= 1'b0;
      pci_rdata <= ~pci_rdata;
    end
    else if (pci_req && !pci_ack && !pci_stall)
    begin
      pwait <= !pwait;
      if (pwait)
      begin
        pci_ack <= 1'b1;
        pci_err <= pci_fail;
        pci_rdata <= 64'hA5A5_0F0F_5A5A_F0F0;
        if (pci_we) n_pci_wr <= n_pci_wr + 1;
        if (pci_we) pci_last_addr <= pci_addr;
        if (pci_we) pci_last_data <= pci_wdata;
        if (pci_we) pci_last_size <= pci_size;
      end
    end
  end
endmodule : pcd_partner
